// ---- hdl/lit_defines.svh ----
// register offsets, field positions and reset values for the local interrupt unit
`ifndef LIT_DEFINES_SVH
`define LIT_DEFINES_SVH
`define ADDR_ERR_STATUS 8'h28
`define ADDR_TMR_VECTOR 8'h32
`define ADDR_TMR_INIT 8'h38
`define ADDR_TMR_CUR 8'h39
`define ADDR_TMR_DIV 8'h3e
`define ADDR_REQ_BASE 8'h20
`define ADDR_REQ_LAST 8'h27
`define ADDR_IRQ_STATUS 8'h40
`define ADDR_IRQ_CLEAR 8'h41
`define ADDR_IRQ_ENABLE 8'h42
`define ADDR_VEC_IN 8'h43
`define BIT_ILLEGAL_VEC 6
`define BIT_VEC_PENDING 12
`define BIT_VEC_MASK 16
`define BIT_VEC_PERIODIC 17
`define VEC_ILLEGAL_MAX 8'h0f
`define EV_ILLEGAL 0
`define EV_ERRINT 1
`define EV_TIMER 2
`define DELIVER_CYCLES 4'h3
`define VEC_RESET 32'h0001_0000
`endif

// ---- hdl/lit_pkg.sv ----
// types for the local interrupt unit
package lit_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
    typedef enum logic [1:0] {
        DLV_IDLE = 2'b00,
        DLV_SEND = 2'b01,
        DLV_POST = 2'b10
    } dlv_state_type;
endpackage

// ---- hdl/lit_prescale.sv ----
// divide-configuration prescaler producing count ticks
`timescale 1ns/100ps
`include "lit_defines.svh"
module lit_prescale
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] div_i,
    input wire logic run_i,
    output logic tick_o
);
    logic [7:0] pre;
    logic [2:0] sel;
    // divide code bits 3,1,0 select a power of two, 3'b111 means by one
    always_comb
    begin
        sel = {div_i[3], div_i[1:0]};
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pre <= 8'h00;
        else if (!run_i)
            pre <= 8'h00;
        else
            pre <= pre + 8'h01;
    end
    always_comb
    begin
        if (sel == 3'b111)
            tick_o = run_i;
        else
            tick_o = run_i && (pre[sel] == 1'b1) && (&pre[sel -: 1] || sel == 3'h0)
                && ((pre & ((8'h01 << (sel + 3'h1)) - 8'h01)) == ((8'h01 << (sel + 3'h1)) - 8'h01));
    end
endmodule

// ---- hdl/lit_sticky.sv ----
// sticky event bits with set winning over clear
`timescale 1ns/100ps
module lit_sticky
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : bits
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    q_o[g] <= 1'b0;
                else if (set_i[g])
                    q_o[g] <= 1'b1;
                else if (clr_i[g])
                    q_o[g] <= 1'b0;
            end
        end
    endgenerate
endmodule

// ---- hdl/local_intc_timer_error_log.sv ----
// error log and timer delivery logic of the local interrupt unit
// Behaviour
// - an incoming message with an illegal vector sets bit 6 of the error status register.
// - an illegal vector arriving in the same cycle as a write to error status is still logged.
// - every logged illegal vector raises the error interrupt, even during an error status write.
// - the timer entry delivery-status bit stays set for the whole timer delivery.
// - on acceptance the request bit chosen by the timer entry vector is set.
// - with count zero and both status and request bits clear, no more timer delivery follows.
// - delivery visibility holds for every divide setting, including four and above.
// - writing zero to the initial count stops the timer and cancels any pending delivery.
`timescale 1ns/100ps
`include "lit_defines.svh"
module local_intc_timer_error_log
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic VEC_VALID_I,
    input wire logic [7:0] VEC_I,
    output logic [31:0] RDATA_O,
    output logic IRQ_O,
    output logic ERR_INT_O
);
    lit_pkg::bus_req_type req;
    lit_pkg::dlv_state_type dlv_state;
    lit_pkg::dlv_state_type next_dlv_state;
    logic [7:0] error_status_reg;
    logic [31:0] timer_vector_entry;
    logic [31:0] timer_init_count;
    logic [31:0] timer_current_count;
    logic [3:0] timer_divide_config;
    logic [255:0] interrupt_request_bits;
    logic [2:0] irq_enable;
    logic [2:0] irq_status;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic [3:0] dlv_cnt;
    logic [7:0] last_vec;
    logic tick;
    logic running;
    logic expire;
    logic illegal;
    logic accept;
    logic init_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    always_comb
    begin
        req.addr = ADDR_I;
        req.wdata = WDATA_I;
        req.wr = WR_I;
        req.rd = RD_I;
    end

    assign illegal = VEC_VALID_I && (VEC_I <= `VEC_ILLEGAL_MAX);
    assign init_wr = req.wr && hit(req.addr, `ADDR_TMR_INIT);
    assign running = (timer_current_count != 32'h0000_0000);
    assign expire = running && tick && (timer_current_count == 32'h0000_0001);
    assign accept = (dlv_state == lit_pkg::DLV_SEND) && (dlv_cnt == 4'h0);

    lit_prescale u_pre
    (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .div_i(timer_divide_config),
        .run_i(running),
        .tick_o(tick)
    );

    // error status: write clears, a coincident illegal vector wins
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            error_status_reg <= 8'h00;
        else
        begin
            if (req.wr && hit(req.addr, `ADDR_ERR_STATUS))
                error_status_reg <= 8'h00;
            if (illegal)
                error_status_reg[`BIT_ILLEGAL_VEC] <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            last_vec <= 8'h00;
        else if (VEC_VALID_I)
            last_vec <= VEC_I;
    end

    // error interrupt pulse for each logged illegal vector
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ERR_INT_O <= 1'b0;
        else
            ERR_INT_O <= illegal;
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            timer_divide_config <= 4'h0;
            irq_enable <= 3'h0;
        end
        else if (req.wr)
        begin
            if (hit(req.addr, `ADDR_TMR_DIV))
                timer_divide_config <= req.wdata[3:0];
            if (hit(req.addr, `ADDR_IRQ_ENABLE))
                irq_enable <= req.wdata[2:0];
        end
    end

    // vector entry; delivery-status bit is hardware owned
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            timer_vector_entry <= `VEC_RESET;
        else
        begin
            if (req.wr && hit(req.addr, `ADDR_TMR_VECTOR))
                timer_vector_entry <= req.wdata;
            timer_vector_entry[`BIT_VEC_PENDING] <= (next_dlv_state == lit_pkg::DLV_SEND);
        end
    end

    // initial and current count
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            timer_init_count <= 32'h0000_0000;
            timer_current_count <= 32'h0000_0000;
        end
        else if (init_wr)
        begin
            timer_init_count <= req.wdata;
            timer_current_count <= req.wdata;
        end
        else if (expire && timer_vector_entry[`BIT_VEC_PERIODIC])
            timer_current_count <= timer_init_count;
        else if (running && tick)
            timer_current_count <= timer_current_count - 32'h0000_0001;
    end

    // delivery sequencer
    always_comb
    begin
        next_dlv_state = dlv_state;
        unique case (dlv_state)
            lit_pkg::DLV_IDLE:
                if (expire && !timer_vector_entry[`BIT_VEC_MASK] && !init_wr)
                    next_dlv_state = lit_pkg::DLV_SEND;
            lit_pkg::DLV_SEND:
                if (init_wr && req.wdata == 32'h0000_0000)
                    next_dlv_state = lit_pkg::DLV_IDLE;
                else if (accept)
                    next_dlv_state = lit_pkg::DLV_POST;
            lit_pkg::DLV_POST:
                next_dlv_state = lit_pkg::DLV_IDLE;
            default:
                next_dlv_state = lit_pkg::DLV_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            dlv_state <= lit_pkg::DLV_IDLE;
        else
            dlv_state <= next_dlv_state;
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            dlv_cnt <= 4'h0;
        else if (dlv_state == lit_pkg::DLV_IDLE)
            dlv_cnt <= `DELIVER_CYCLES;
        else if (dlv_cnt != 4'h0)
            dlv_cnt <= dlv_cnt - 4'h1;
    end

    // request bits: set on acceptance in the same edge that clears delivery status
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            interrupt_request_bits <= '0;
        else
        begin
            if (req.wr && req.addr >= `ADDR_REQ_BASE && req.addr <= `ADDR_REQ_LAST)
                interrupt_request_bits[{req.addr[2:0], 5'h00} +: 32] <= 32'h0000_0000;
            if (accept && next_dlv_state == lit_pkg::DLV_POST)
                interrupt_request_bits[timer_vector_entry[7:0]] <= 1'b1;
        end
    end

    always_comb
    begin
        ev_set = 3'h0;
        ev_set[`EV_ILLEGAL] = illegal;
        ev_set[`EV_ERRINT] = illegal;
        ev_set[`EV_TIMER] = accept && next_dlv_state == lit_pkg::DLV_POST;
        ev_clr = (req.wr && hit(req.addr, `ADDR_IRQ_CLEAR)) ? req.wdata[2:0] : 3'h0;
    end

    lit_sticky #(.WIDTH(3)) u_sticky
    (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .set_i(ev_set),
        .clr_i(ev_clr),
        .q_o(irq_status)
    );

    assign IRQ_O = |(irq_status & irq_enable);

    // read data one cycle after the strobe
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 32'h0000_0000;
        else if (!req.rd)
            RDATA_O <= 32'h0000_0000;
        else if (req.addr >= `ADDR_REQ_BASE && req.addr <= `ADDR_REQ_LAST)
            RDATA_O <= interrupt_request_bits[{req.addr[2:0], 5'h00} +: 32];
        else
        begin
            unique case (req.addr)
                `ADDR_ERR_STATUS: RDATA_O <= {24'h000000, error_status_reg};
                `ADDR_TMR_VECTOR: RDATA_O <= timer_vector_entry;
                `ADDR_TMR_INIT: RDATA_O <= timer_init_count;
                `ADDR_TMR_CUR: RDATA_O <= timer_current_count;
                `ADDR_TMR_DIV: RDATA_O <= {28'h0000000, timer_divide_config};
                `ADDR_IRQ_STATUS: RDATA_O <= {29'h00000000, irq_status};
                `ADDR_IRQ_ENABLE: RDATA_O <= {29'h00000000, irq_enable};
                `ADDR_VEC_IN: RDATA_O <= {24'h000000, last_vec};
                default: RDATA_O <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- tb/local_intc_timer_error_log_sva.sv ----
// port checker for the local interrupt unit
`timescale 1ns/100ps
`include "lit_defines.svh"
module lit_chk
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic VEC_VALID_I,
    input wire logic [7:0] VEC_I,
    input wire logic [31:0] RDATA_O,
    input wire logic IRQ_O,
    input wire logic ERR_INT_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic bad;
    assign bad = VEC_VALID_I && (VEC_I <= `VEC_ILLEGAL_MAX);
    sequence s_bad_on_clear;
        bad && WR_I && ADDR_I == `ADDR_ERR_STATUS;
    endsequence
    sequence s_rd_err;
        RD_I && ADDR_I == `ADDR_ERR_STATUS;
    endsequence
    a_err_int_cause: assert property (ERR_INT_O |-> $past(bad))
        else $error("error pulse without illegal vector");
    a_err_int_follow: assert property (bad |=> ERR_INT_O)
        else $error("illegal vector without error pulse");
    a_log_on_clear: assert property (s_bad_on_clear ##1 !WR_I ##1 s_rd_err |=> RDATA_O[6])
        else $error("illegal vector lost on clear");
    a_log_bad_vec: assert property (bad ##1 !WR_I ##1 s_rd_err |=> RDATA_O[6])
        else $error("illegal vector flag not set");
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside read slot");
    a_stop_count: assert property ((WR_I && ADDR_I == `ADDR_TMR_INIT && WDATA_I == 32'h0)
        ##1 !WR_I ##1 (RD_I && ADDR_I == `ADDR_TMR_CUR) |=> RDATA_O == 32'h0)
        else $error("count not stopped");
    a_load_count: assert property ((WR_I && ADDR_I == `ADDR_TMR_INIT && WDATA_I > 32'h2)
        ##1 !WR_I ##1 (RD_I && ADDR_I == `ADDR_TMR_CUR) |=> RDATA_O != 0 && RDATA_O <= $past(WDATA_I, 3))
        else $error("count not loaded");
    a_irq_masked: assert property ((WR_I && ADDR_I == `ADDR_IRQ_ENABLE && WDATA_I[2:0] == 3'h0) |=> !IRQ_O)
        else $error("irq while all masked");
    a_irq_on_bad: assert property ((WR_I && ADDR_I == `ADDR_IRQ_ENABLE && WDATA_I[0]) ##1 !WR_I
        ##1 (bad && !WR_I) |=> IRQ_O)
        else $error("irq missing");
    a_last_vec: assert property (VEC_VALID_I ##1 !VEC_VALID_I
        ##1 (RD_I && ADDR_I == `ADDR_VEC_IN && !VEC_VALID_I) |=> RDATA_O[7:0] == $past(VEC_I, 3))
        else $error("last vector wrong");
endmodule

// ---- tb/test_local_intc_timer_error_log.sv ----
// self-checking bench for the local interrupt unit
`timescale 1ns/100ps
`include "lit_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_local_intc_timer_error_log;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lit_pkg::bus_req_type req = '0;
    logic vv = 1'b0;
    logic [7:0] vec = 8'h00;
    logic [31:0] rdata;
    logic irq;
    logic eint;
    logic [31:0] d;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    initial forever #20 clk = ~clk;
    local_intc_timer_error_log u_local_intc_timer_error_log (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .ADDR_I(req.addr), .WDATA_I(req.wdata), .WR_I(req.wr), .RD_I(req.rd), .VEC_VALID_I(vv),
        .VEC_I(vec), .RDATA_O(rdata), .IRQ_O(irq), .ERR_INT_O(eint));
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            summarize();
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task pulse_vec(input logic [7:0] v, input logic clr);
        @(posedge clk);
        vv <= 1'b1;
        vec <= v;
        req <= '{addr: `ADDR_ERR_STATUS, wdata: 32'h0, wr: clr, rd: 1'b0};
        @(posedge clk);
        vv <= 1'b0;
        req.wr <= 1'b0;
        #1;
    endtask
    task t_reset;
        rd(`ADDR_TMR_VECTOR);
        `CHK("vector entry", `VEC_RESET, d)
        rd(8'h10);
        `CHK("unmapped", 32'h0, d)
        $display("t_reset done");
    endtask
    task t_err;
        pulse_vec(8'h05, 1'b1);
        `CHK("err pulse on clear", 1'b1, eint)
        rd(`ADDR_ERR_STATUS);
        `CHK("flag on clear", 1'b1, d[6])
        rd(`ADDR_VEC_IN);
        `CHK("last vector", 8'h05, d[7:0])
        wr(`ADDR_ERR_STATUS, 32'h0);
        pulse_vec(8'h0f, 1'b0);
        `CHK("err pulse", 1'b1, eint)
        rd(`ADDR_ERR_STATUS);
        `CHK("flag", 1'b1, d[6])
        wr(`ADDR_ERR_STATUS, 32'h0);
        pulse_vec(8'h10, 1'b0);
        `CHK("no pulse legal", 1'b0, eint)
        rd(`ADDR_ERR_STATUS);
        `CHK("no flag legal", 32'h0, d)
        pulse_vec(8'h20, 1'b0);
        rd(`ADDR_VEC_IN);
        `CHK("last legal vector", 8'h20, d[7:0])
        $display("t_err done");
    endtask
    task t_irq;
        wr(`ADDR_IRQ_CLEAR, 32'h7);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        pulse_vec(8'h01, 1'b0);
        rd(`ADDR_IRQ_STATUS);
        `CHK("irq status", 32'h3, d)
        `CHK("irq masked", 1'b0, irq)
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        `CHK("irq raised", 1'b1, irq)
        wr(`ADDR_IRQ_CLEAR, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        pulse_vec(8'h02, 1'b0);
        `CHK("irq on vector", 1'b1, irq)
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        $display("t_irq done");
    endtask
    task t_timer(input logic [3:0] div, input logic [31:0] cnt);
        int n;
        wr(`ADDR_IRQ_CLEAR, 32'h7);
        wr(`ADDR_TMR_DIV, {28'h0, div});
        wr(`ADDR_TMR_VECTOR, 32'h48);
        wr(`ADDR_TMR_INIT, cnt);
        d = '0;
        n = 0;
        while (d[12] !== 1'b1 && n < 400)
        begin
            rd(`ADDR_TMR_VECTOR);
            n++;
        end
        `CHK("delivery seen", 1'b1, d[12])
        while (d[12] === 1'b1 && n < 400)
        begin
            rd(`ADDR_TMR_VECTOR);
            n++;
        end
        rd(8'h22);
        `CHK("request bit", 32'h100, d)
        rd(`ADDR_TMR_CUR);
        `CHK("count at zero", 32'h0, d)
        rd(`ADDR_IRQ_STATUS);
        `CHK("timer accepted", 1'b1, d[2])
        wr(8'h22, 32'h0);
        repeat (40) @(posedge clk);
        rd(8'h22);
        `CHK("no second request", 32'h0, d)
        rd(`ADDR_TMR_VECTOR);
        `CHK("no second delivery", 1'b0, d[12])
        $display("t_timer done");
    endtask
    task t_stop;
        wr(`ADDR_IRQ_CLEAR, 32'h7);
        wr(`ADDR_TMR_DIV, 32'hb);
        wr(`ADDR_TMR_INIT, 32'h20);
        rd(`ADDR_TMR_CUR);
        `CHK("count loaded", 32'h1f, d)
        repeat (10) @(posedge clk);
        wr(`ADDR_TMR_INIT, 32'h0);
        rd(`ADDR_TMR_CUR);
        `CHK("count cleared", 32'h0, d)
        repeat (100) @(posedge clk);
        rd(`ADDR_TMR_CUR);
        `CHK("stopped count", 32'h0, d)
        rd(`ADDR_IRQ_STATUS);
        `CHK("no timer event", 1'b0, d[2])
        rd(8'h22);
        `CHK("no request", 32'h0, d)
        wr(`ADDR_TMR_INIT, 32'h3);
        repeat (2) @(posedge clk);
        wr(`ADDR_TMR_INIT, 32'h0);
        repeat (10) @(posedge clk);
        rd(8'h22);
        `CHK("delivery cancelled", 32'h0, d)
        rd(`ADDR_IRQ_STATUS);
        `CHK("no late timer event", 1'b0, d[2])
        $display("t_stop done");
    endtask
    task t_modes;
        wr(`ADDR_IRQ_CLEAR, 32'h7);
        wr(`ADDR_TMR_DIV, 32'hb);
        wr(`ADDR_TMR_VECTOR, 32'h0001_0048);
        wr(`ADDR_TMR_INIT, 32'h3);
        repeat (20) @(posedge clk);
        rd(8'h22);
        `CHK("masked no request", 32'h0, d)
        wr(`ADDR_TMR_VECTOR, 32'h0002_0048);
        wr(`ADDR_TMR_INIT, 32'h3);
        repeat (20) @(posedge clk);
        rd(`ADDR_TMR_CUR);
        `CHK("periodic reload", 1'b1, d != 32'h0)
        rd(8'h22);
        `CHK("periodic request", 32'h100, d)
        wr(`ADDR_TMR_INIT, 32'h0);
        wr(8'h22, 32'h0);
        wr(`ADDR_TMR_VECTOR, 32'h48);
        $display("t_modes done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_err();
        t_irq();
        t_timer(4'hb, 32'h5);
        t_timer(4'h4, 32'h4);
        t_timer(4'h9, 32'h3);
        t_stop();
        t_modes();
        summarize();
    end
endmodule
bind local_intc_timer_error_log lit_chk u_lit_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .VEC_VALID_I(VEC_VALID_I), .VEC_I(VEC_I),
    .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .ERR_INT_O(ERR_INT_O));
